// [common/rfe_consts.vh]
/*
 * Constants of the receive-side API frame emitter: framing bytes, frame
 * types, field constants, register offsets and reset values.
 * Assumes inclusion by bare name from the design files and the bench.
 */
`ifndef RFE_CONSTS_VH
`define RFE_CONSTS_VH

// ----------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------
`define RFE_START_DELIM      8'h7E
`define RFE_CSUM_BASE        8'hFF
`define RFE_CSUM_FIRST_OFS   2'h3
`define RFE_TYPE_RX          8'h90
`define RFE_TYPE_RX_EXPL     8'h91
`define RFE_TYPE_IO          8'h92
`define RFE_TYPE_ADDR_UPD    8'h8E
`define RFE_RESV_16          16'hFFFE
`define RFE_RESV_8           8'h00
`define RFE_DMASK_VALID      16'h0FFF
`define RFE_BODY_RX          8'h0C
`define RFE_BODY_RX_EXPL     8'h12
`define RFE_BODY_IO          8'h10
`define RFE_BODY_ADDR_UPD    8'h12
`define RFE_EXPL_BIT         1

// ----------------------------------------------------------------------
// Register map (byte addresses), reset values and bus response codes
// ----------------------------------------------------------------------
`define RFE_REG_OUTOPT       8'h00
`define RFE_REG_MODE         8'h04
`define RFE_REG_DEST_HI      8'h08
`define RFE_REG_DEST_LO      8'h0C
`define RFE_REG_STATUS       8'h10
`define RFE_RST_OUTOPT       8'h00
`define RFE_RST_MODE         1'h1
`define RFE_RST_DEST         64'h0000000000000000
`define RFE_RESP_OKAY        2'h0
`define RFE_RESP_SLVERR      2'h2

`endif

// [hdl/rfe_csum.v]
/*
 * Running checksum of a frame's bytes from the type byte to the last
 * byte before the checksum.
 * Assumes the caller clears it at frame start and adds each covered byte.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfe_consts.vh"

module rfe_csum (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       srst,
	// Accumulation
	input  wire       clr,
	input  wire       add_en,
	input  wire [7:0] add_byte,
	// Result
	output wire [7:0] csum
);

	reg [7:0] sum_r;

	always @(posedge sys_clk) begin
		if (srst || clr) begin
			sum_r <= 8'h00;
		end else if (add_en) begin
			sum_r <= sum_r + add_byte;
		end
	end

	// Only the low eight bits of the sum matter, so the wrap is wanted.
	assign csum = `RFE_CSUM_BASE - sum_r;

endmodule // rfe_csum

`default_nettype wire

// [hdl/rfe_frame_emitter.v]
/*
 * Receive-side API frame emitter: builds standard receive, explicit receive,
 * I/O sample and address-update frames and sends them as a byte stream.
 * Assumes the radio side offers requests with valid/ready and streams
 * exactly the announced number of payload bytes; software on AXI4-Lite.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfe_consts.vh"

module rfe_frame_emitter (
	// Clock and reset
	input  wire         sys_clk,
	input  wire         srst,
	// AXI4-Lite slave
	input  wire [7:0]   s_axi_awaddr,
	input  wire         s_axi_awvalid,
	output wire         s_axi_awready,
	input  wire [31:0]  s_axi_wdata,
	input  wire [3:0]   s_axi_wstrb,
	input  wire         s_axi_wvalid,
	output wire         s_axi_wready,
	output reg  [1:0]   s_axi_bresp,
	output reg          s_axi_bvalid,
	input  wire         s_axi_bready,
	input  wire [7:0]   s_axi_araddr,
	input  wire         s_axi_arvalid,
	output wire         s_axi_arready,
	output reg  [31:0]  s_axi_rdata,
	output reg  [1:0]   s_axi_rresp,
	output reg          s_axi_rvalid,
	input  wire         s_axi_rready,
	// Received radio data packet
	input  wire         rx_valid,
	output wire         rx_ready,
	input  wire [63:0]  rx_src_addr,
	input  wire [7:0]   rx_opts,
	input  wire [7:0]   rx_src_ep,
	input  wire [7:0]   rx_dst_ep,
	input  wire [15:0]  rx_cluster,
	input  wire [15:0]  rx_profile,
	input  wire [15:0]  rx_len,
	// Payload bytes of the accepted packet
	input  wire         pld_valid,
	output wire         pld_ready,
	input  wire [7:0]   pld_data,
	// Received I/O sample message
	input  wire         io_valid,
	output wire         io_ready,
	input  wire [63:0]  io_src_addr,
	input  wire [7:0]   io_opts,
	input  wire [7:0]   io_nsamp,
	input  wire [15:0]  io_dmask,
	input  wire [7:0]   io_amask,
	input  wire [15:0]  io_dsamp,
	input  wire [63:0]  io_asamp,
	// Destination address update request
	input  wire         upd_valid,
	output wire         upd_ready,
	input  wire [63:0]  upd_new_addr,
	// Serial API byte stream
	output wire         tx_valid,
	input  wire         tx_ready,
	output wire [7:0]   tx_data
);

	localparam [1:0] K_RX   = 2'h0;
	localparam [1:0] K_IO   = 2'h1;
	localparam [1:0] K_UPD  = 2'h2;
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_HEAD = 3'h1;
	localparam [2:0] S_BODY = 3'h2;
	localparam [2:0] S_PLD  = 3'h3;
	localparam [2:0] S_CSUM = 3'h4;
	localparam [63:0] RST_DEST = `RFE_RST_DEST;

	// ------------------------------------------------------------------
	// Registers reached over the bus
	// ------------------------------------------------------------------
	reg  [7:0]   output_format_options_r;
	reg          api_mode_r;
	reg  [31:0]  destination_address_upper_r;
	reg  [31:0]  destination_address_lower_r;
	reg  [15:0]  frame_cnt_r;
	reg  [7:0]   io_drop_cnt_r;
	reg  [7:0]   aw_addr_r;
	reg          aw_got_r;
	reg  [31:0]  w_data_r;
	reg  [3:0]   w_strb_r;
	reg          w_got_r;
	wire [63:0]  dest_addr;
	wire         wr_go;
	wire         busy;
	integer      b;
	integer      k;

	assign dest_addr     = {destination_address_upper_r, destination_address_lower_r};
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_got_r && w_got_r && !s_axi_bvalid;

	// ------------------------------------------------------------------
	// Frame sequencer state
	// ------------------------------------------------------------------
	reg  [2:0]   st_r;
	reg  [1:0]   idx_r;
	reg  [207:0] body_r;
	reg  [7:0]   body_cnt_r;
	reg  [15:0]  len_r;
	reg  [15:0]  pld_cnt_r;
	reg  [7:0]   out_data_r;
	reg          out_v_r;
	reg  [207:0] body_nxt;
	reg  [7:0]   body_n_nxt;
	reg  [1:0]   kind;
	reg  [79:0]  tail;
	reg  [2:0]   tail_n;
	reg  [7:0]   byte_nxt;
	reg          push;
	wire         slot_free;
	wire         accept;
	wire         io_pass;
	wire         io_drop;
	wire [7:0]   csum;
	wire [15:0]  dmask_v;

	assign busy      = (st_r != S_IDLE) || out_v_r;
	assign slot_free = !out_v_r || tx_ready;
	assign upd_ready = (st_r == S_IDLE);
	assign io_ready  = (st_r == S_IDLE) && !upd_valid;
	assign rx_ready  = (st_r == S_IDLE) && !upd_valid && !io_valid;
	assign pld_ready = (st_r == S_PLD) && slot_free && (pld_cnt_r != 16'h0000);
	assign io_pass   = (output_format_options_r == 8'h00) && api_mode_r;
	assign io_drop   = io_valid && io_ready && !io_pass;
	// A dropped sample must not open a frame of the wrong kind.
	assign accept    = upd_valid || (io_valid && io_pass) || (rx_valid && rx_ready);
	assign dmask_v   = io_dmask & `RFE_DMASK_VALID;
	assign tx_valid  = out_v_r;
	assign tx_data   = out_data_r;

	// ------------------------------------------------------------------
	// AXI4-Lite write and read channels
	// ------------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (srst) begin
			aw_got_r                    <= 1'b0;
			w_got_r                     <= 1'b0;
			aw_addr_r                   <= 8'h00;
			w_data_r                    <= 32'h00000000;
			w_strb_r                    <= 4'h0;
			s_axi_bvalid                <= 1'b0;
			s_axi_bresp                 <= `RFE_RESP_OKAY;
			output_format_options_r     <= `RFE_RST_OUTOPT;
			api_mode_r                  <= `RFE_RST_MODE;
			destination_address_upper_r <= RST_DEST[63:32];
			destination_address_lower_r <= RST_DEST[31:0];
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r  <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RFE_RESP_OKAY;
				case (aw_addr_r)
				`RFE_REG_OUTOPT: begin
					if (w_strb_r[0])
						output_format_options_r <= w_data_r[7:0];
				end
				`RFE_REG_MODE: begin
					if (w_strb_r[0])
						api_mode_r <= w_data_r[0];
				end
				`RFE_REG_DEST_HI: begin
					for (b = 0; b < 4; b = b + 1)
						if (w_strb_r[b])
							destination_address_upper_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
				end
				`RFE_REG_DEST_LO: begin
					for (b = 0; b < 4; b = b + 1)
						if (w_strb_r[b])
							destination_address_lower_r[b*8 +: 8] <= w_data_r[b*8 +: 8];
				end
				`RFE_REG_STATUS: begin
					s_axi_bresp <= `RFE_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `RFE_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// A network update lands after any software write in the same cycle.
			if (upd_valid && upd_ready) begin
				destination_address_upper_r <= upd_new_addr[63:32];
				destination_address_lower_r <= upd_new_addr[31:0];
			end
		end
	end

	always @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RFE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RFE_RESP_OKAY;
			case (s_axi_araddr)
			`RFE_REG_OUTOPT:  s_axi_rdata <= {24'h000000, output_format_options_r};
			`RFE_REG_MODE:    s_axi_rdata <= {31'h00000000, api_mode_r};
			`RFE_REG_DEST_HI: s_axi_rdata <= destination_address_upper_r;
			`RFE_REG_DEST_LO: s_axi_rdata <= destination_address_lower_r;
			`RFE_REG_STATUS:  s_axi_rdata <= {io_drop_cnt_r, 7'h00, busy, frame_cnt_r};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RFE_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Frame body assembly, left aligned from offset 3
	// ------------------------------------------------------------------
	always @* begin
		tail       = 80'h0;
		tail_n     = 3'h0;
		body_nxt   = 208'h0;
		body_n_nxt = 8'h00;
		kind       = K_RX;
		if (upd_valid) begin
			kind       = K_UPD;
			body_nxt   = {`RFE_TYPE_ADDR_UPD, `RFE_RESV_8, upd_new_addr, dest_addr,
			              64'h0};
			body_n_nxt = `RFE_BODY_ADDR_UPD;
		end else if (io_valid) begin
			kind = K_IO;
			if (dmask_v != 16'h0000) begin
				tail   = {tail[63:0], io_dsamp & dmask_v};
				tail_n = tail_n + 3'h1;
			end
			for (k = 0; k < 4; k = k + 1) begin
				if (io_amask[k]) begin
					tail   = {tail[63:0], io_asamp[k*16 +: 16]};
					tail_n = tail_n + 3'h1;
				end
			end
			tail       = tail << (16 * (5 - tail_n));
			body_nxt   = {`RFE_TYPE_IO, io_src_addr, `RFE_RESV_16, io_opts, io_nsamp,
			              dmask_v, io_amask, tail};
			body_n_nxt = `RFE_BODY_IO + {4'h0, tail_n, 1'b0};
		end else if (output_format_options_r[`RFE_EXPL_BIT]) begin
			body_nxt   = {`RFE_TYPE_RX_EXPL, rx_src_addr, `RFE_RESV_16, rx_src_ep,
			              rx_dst_ep, rx_cluster, rx_profile, rx_opts, 64'h0};
			body_n_nxt = `RFE_BODY_RX_EXPL;
		end else begin
			body_nxt   = {`RFE_TYPE_RX, rx_src_addr, `RFE_RESV_16, rx_opts,
			              112'h0};
			body_n_nxt = `RFE_BODY_RX;
		end
	end

	// ------------------------------------------------------------------
	// Byte selection for the output slot
	// ------------------------------------------------------------------
	always @* begin
		push     = 1'b0;
		byte_nxt = 8'h00;
		case (st_r)
		S_HEAD: begin
			push = slot_free;
			case (idx_r)
			2'h0:    byte_nxt = `RFE_START_DELIM;
			2'h1:    byte_nxt = len_r[15:8];
			default: byte_nxt = len_r[7:0];
			endcase
		end
		S_BODY: begin
			push     = slot_free;
			byte_nxt = body_r[207:200];
		end
		S_PLD: begin
			push     = pld_valid && pld_ready;
			byte_nxt = pld_data;
		end
		S_CSUM: begin
			push     = slot_free;
			byte_nxt = csum;
		end
		default: begin
			push     = 1'b0;
			byte_nxt = 8'h00;
		end
		endcase
	end

	// Only the type byte onward enters the sum, hence body and payload.
	rfe_csum u_csum (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.clr      (st_r == S_IDLE),
		.add_en   (push && (st_r == S_BODY || st_r == S_PLD)),
		.add_byte (byte_nxt),
		.csum     (csum)
	);

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (srst) begin
			st_r          <= S_IDLE;
			idx_r         <= 2'h0;
			body_r        <= 208'h0;
			body_cnt_r    <= 8'h00;
			len_r         <= 16'h0000;
			pld_cnt_r     <= 16'h0000;
			out_v_r       <= 1'b0;
			out_data_r    <= 8'h00;
			frame_cnt_r   <= 16'h0000;
			io_drop_cnt_r <= 8'h00;
		end else begin
			if (push) begin
				out_v_r    <= 1'b1;
				out_data_r <= byte_nxt;
			end else if (tx_ready) begin
				out_v_r <= 1'b0;
			end
			if (io_drop)
				io_drop_cnt_r <= io_drop_cnt_r + 8'h01;
			case (st_r)
			S_IDLE: begin
				if (accept) begin
					st_r       <= S_HEAD;
					idx_r      <= 2'h0;
					body_r     <= body_nxt;
					body_cnt_r <= body_n_nxt;
					// Length spans type byte to last payload byte only.
					if (kind == K_RX) begin
						len_r     <= {8'h00, body_n_nxt} + rx_len;
						pld_cnt_r <= rx_len;
					end else begin
						len_r     <= {8'h00, body_n_nxt};
						pld_cnt_r <= 16'h0000;
					end
				end
			end
			S_HEAD: begin
				if (push) begin
					idx_r <= idx_r + 2'h1;
					if (idx_r == 2'h2)
						st_r <= S_BODY;
				end
			end
			S_BODY: begin
				if (push) begin
					body_r     <= body_r << 8;
					body_cnt_r <= body_cnt_r - 8'h01;
					if (body_cnt_r == 8'h01)
						st_r <= S_PLD;
				end
			end
			S_PLD: begin
				if (pld_cnt_r == 16'h0000)
					st_r <= S_CSUM;
				else if (push)
					pld_cnt_r <= pld_cnt_r - 16'h0001;
			end
			S_CSUM: begin
				if (push) begin
					st_r        <= S_IDLE;
					frame_cnt_r <= frame_cnt_r + 16'h0001;
				end
			end
			default: begin
				st_r <= S_IDLE;
			end
			endcase
		end
	end

endmodule // rfe_frame_emitter

`default_nettype wire

// [verif/rfe_emitter_properties.sv]
/* Checker on the frame emitter's request and stream ports.
   Assumes binding onto rfe_frame_emitter. */
`timescale 1ns/1ps
`default_nettype none
module rfe_emitter_properties (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       srst,
	// Serial stream
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic [7:0] tx_data,
	// Requests
	input wire logic       upd_valid,
	input wire logic       upd_ready,
	input wire logic       io_valid,
	input wire logic       io_ready,
	input wire logic       rx_valid,
	input wire logic       rx_ready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_delim;
		tx_valid && tx_data == 8'h7E;
	endsequence
	sequence s_upd_take;
		upd_valid && upd_ready;
	endsequence
	a_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("stalled byte changed");
	a_upd_delim: assert property (s_upd_take |-> ##[2:3] s_delim)
		else $error("update frame without delimiter");
	a_rx_delim: assert property (rx_valid && rx_ready |-> ##[2:3] s_delim)
		else $error("receive frame without delimiter");
	a_upd_first: assert property (upd_valid |-> !io_ready && !rx_ready)
		else $error("update request not served first");
	a_io_before_rx: assert property (io_valid |-> !rx_ready)
		else $error("sample request not served before data");
	a_busy_blocks: assert property (rx_valid && rx_ready |=> !upd_ready && !io_ready && !rx_ready)
		else $error("request taken in mid frame");
	a_upd_busy: assert property (s_upd_take |=> !upd_ready [*2])
		else $error("ready back too soon");
	a_idle_quiet: assert property (upd_ready && !upd_valid && !io_valid && !rx_valid
		&& (!tx_valid || tx_ready) |=> !tx_valid)
		else $error("byte sent with no request");
endmodule // rfe_emitter_properties
bind rfe_frame_emitter rfe_emitter_properties chk (.sys_clk, .srst, .tx_valid, .tx_ready,
	.tx_data, .upd_valid, .upd_ready, .io_valid, .io_ready, .rx_valid, .rx_ready);
`default_nettype wire

// [verif/rfe_frame_emitter_bench.sv]
/* Bench for the frame emitter: registers, every frame kind, gating of samples.
   Assumes the host model and the checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
`include "rfe_consts.vh"
module rfe_frame_emitter_bench;
	localparam logic [63:0] SRC = 64'h0013A20012345678;
	logic        sys_clk = 1'b0, srst = 1'b1, slow = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, rx_valid = 1'b0;
	logic        pld_valid = 1'b0, io_valid = 1'b0, upd_valid = 1'b0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, pld_data = '0, rx_opts = '0;
	logic [7:0]  rx_src_ep = '0, rx_dst_ep = '0, io_opts = '0, io_nsamp = '0, io_amask = '0;
	logic [15:0] rx_cluster = '0, rx_profile = '0, rx_len = '0, io_dmask = '0, io_dsamp = '0;
	logic [31:0] s_axi_wdata = '0, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [63:0] rx_src_addr = '0, io_src_addr = '0, io_asamp = '0, upd_new_addr = '0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        rx_ready, pld_ready, io_ready, upd_ready, tx_valid, tx_ready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata;
	logic [7:0]  tx_data;
	logic [7:0]  exp_body[$];
	int          num_errors = 0, checked = 0, frames_seen = 0, cycles = 0;

	rfe_frame_emitter uut (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_ready, .rx_src_addr,
		.rx_opts, .rx_src_ep, .rx_dst_ep, .rx_cluster, .rx_profile, .rx_len, .pld_valid,
		.pld_ready, .pld_data, .io_valid, .io_ready, .io_src_addr, .io_opts, .io_nsamp,
		.io_dmask, .io_amask, .io_dsamp, .io_asamp, .upd_valid, .upd_ready, .upd_new_addr,
		.tx_valid, .tx_ready, .tx_data);
	rfe_host_model host (.sys_clk, .srst, .slow, .tx_valid, .tx_ready, .tx_data);

	initial forever #5 sys_clk = ~sys_clk;

	task stop_test;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hung handshake would otherwise stall the run for ever.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test;
		end
	end

	task check(input string what, input logic [63:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task put(input logic [63:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			exp_body.push_back(v[8*i +: 8]);
	endtask

	task expect_frame(input string what);
		logic [7:0] sum;
		int         k;
		sum = 8'h00;
		k = 0;
		while (host.done == frames_seen && k < 600) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 600)
			num_errors++;
		frames_seen = host.done;
		check({what, " size"}, host.last.size(), exp_body.size() + 4);
		check({what, " delim"}, host.last[0], `RFE_START_DELIM);
		check({what, " length"}, {host.last[1], host.last[2]}, exp_body.size());
		foreach (exp_body[i]) begin
			check({what, " body"}, host.last[i + 3], exp_body[i]);
			sum += exp_body[i];
		end
		check({what, " csum"}, host.last[exp_body.size() + 3], 8'hFF - sum);
		exp_body = {};
		$display("test %s done", what);
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
	endtask

	task axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask

	task go_upd;
		upd_valid <= 1'b1;
		do @(posedge sys_clk); while (upd_ready !== 1'b1);
		upd_valid <= 1'b0;
	endtask

	task go_io;
		io_valid <= 1'b1;
		do @(posedge sys_clk); while (io_ready !== 1'b1);
		io_valid <= 1'b0;
	endtask

	task go_rx(input logic [7:0] p[$]);
		rx_len <= 16'(p.size());
		rx_valid <= 1'b1;
		do @(posedge sys_clk); while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		foreach (p[i]) begin
			pld_data <= p[i];
			pld_valid <= 1'b1;
			do @(posedge sys_clk); while (pld_ready !== 1'b1);
			put(p[i], 1);
		end
		pld_valid <= 1'b0;
	endtask

	task t_regs;
		axi_rd(`RFE_REG_OUTOPT);
		check("options reset", rd, 32'h0);
		axi_rd(`RFE_REG_MODE);
		check("mode reset", rd, 32'h1);
		axi_rd(8'h20);
		check("unmapped read", rsp, `RFE_RESP_SLVERR);
		check("unmapped data", rd, 32'h0);
		axi_wr(8'h20, 32'h0);
		check("unmapped write", rsp, `RFE_RESP_SLVERR);
		$display("test regs done");
	endtask

	task t_update;
		axi_wr(`RFE_REG_DEST_HI, 32'h0013A200);
		axi_wr(`RFE_REG_DEST_LO, 32'h4052AAAA);
		upd_new_addr <= 64'h0013A2004052BBBB;
		go_upd;
		put(64'h8E00, 2);
		put(64'h0013A2004052BBBB, 8);
		put(64'h0013A2004052AAAA, 8);
		expect_frame("update");
		axi_rd(`RFE_REG_DEST_LO);
		check("new destination", rd, 32'h4052BBBB);
	endtask

	task t_rx;
		slow <= 1'b1;
		rx_src_addr <= SRC;
		rx_opts <= 8'h03;
		put(64'h90, 1);
		put(SRC, 8);
		put(64'hFFFE03, 3);
		go_rx('{8'h11, 8'h22, 8'h33});
		expect_frame("standard");
		slow <= 1'b0;
		axi_wr(`RFE_REG_OUTOPT, 32'h2);
		rx_src_ep <= 8'hE8;
		rx_dst_ep <= 8'hE6;
		rx_cluster <= 16'h0011;
		rx_profile <= 16'hC105;
		rx_opts <= 8'h02;
		put(64'h91, 1);
		put(SRC, 8);
		put(64'hFFFE, 2);
		put(64'hE8E60011C10502, 7);
		go_rx('{8'hA5});
		expect_frame("explicit");
		axi_wr(`RFE_REG_OUTOPT, 32'h0);
	endtask

	task t_io;
		io_src_addr <= SRC;
		io_opts <= 8'hC1;
		io_nsamp <= 8'h01;
		io_dmask <= 16'hF038;
		io_amask <= 8'h06;
		io_dsamp <= 16'hFF28;
		io_asamp <= 64'h444400F802251111;
		put(64'h92, 1);
		put(SRC, 8);
		put(64'hFFFEC101003806, 7);
		put(64'h0028022500F8, 6);
		go_io;
		expect_frame("samples");
		io_dmask <= 16'h0000;
		io_amask <= 8'h09;
		put(64'h92, 1);
		put(SRC, 8);
		put(64'hFFFEC101000009, 7);
		put(64'h11114444, 4);
		go_io;
		expect_frame("analog only");
	endtask

	task t_gate;
		axi_wr(`RFE_REG_MODE, 32'h0);
		go_io;
		repeat (60) @(posedge sys_clk);
		check("unframed mode", host.done, frames_seen);
		axi_wr(`RFE_REG_MODE, 32'h1);
		axi_wr(`RFE_REG_OUTOPT, 32'h2);
		go_io;
		repeat (60) @(posedge sys_clk);
		check("options nonzero", host.done, frames_seen);
		axi_rd(`RFE_REG_STATUS);
		check("status", rd, 32'h02000005);
		$display("test gate done");
	endtask

	initial begin
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs;
		t_update;
		t_rx;
		t_io;
		t_gate;
		stop_test;
	end
endmodule // rfe_frame_emitter_bench
`default_nettype wire

// [verif/rfe_host_model.sv]
/* Host side of the serial stream: takes bytes and splits them into frames.
   Assumes one byte per tx_valid and tx_ready handshake. */
`timescale 1ns/1ps
`default_nettype none
module rfe_host_model (
	// Clock, reset and pacing
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       slow,
	// Serial stream
	input  wire logic       tx_valid,
	output var  logic       tx_ready,
	input  wire logic [7:0] tx_data
);
	logic [7:0] cur[$];
	logic [7:0] last[$];
	int         done;
	// A slow host takes a byte every other cycle, so the emitter must hold each one.
	always @(posedge sys_clk) begin
		if (srst) begin
			tx_ready <= 1'b1;
			cur = {};
			done <= 0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready && (cur.size() > 0 || tx_data == 8'h7E))
				cur.push_back(tx_data);
			if (cur.size() > 3 && cur.size() == {cur[1], cur[2]} + 4) begin
				last = cur;
				cur = {};
				done <= done + 1;
			end
		end
	end
endmodule // rfe_host_model
`default_nettype wire
